// ===== card_pkg.sv
// constants shared by the card attribute memory and i/o decode block
// assumes a single 200 MHz system clock and synchronous reset
package card_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_MHZ       = 1000 / CLK_PERIOD_NS;

  // reset load time: 0.6 ms at 1 MHz master clock, scales as 1/f
  localparam int LOAD_TW_MS_X10 = 6;
  localparam int LOAD_TW_NS     = LOAD_TW_MS_X10 * 100000 / CLK_MHZ;
  localparam int LOAD_CYCLES    = LOAD_TW_NS / CLK_PERIOD_NS;

  // state machine clock dividers
  localparam int DIV_TEST = 128;
  localparam int DIV_RUN  = 2;

  // attribute space map
  localparam int        ATTR_BYTES  = 120;
  localparam int        MEM_WORDS   = 128;
  localparam int        SAVE_WORDS  = 127;
  localparam logic [9:0] ATTR_BASE  = 10'h000;
  localparam logic [9:0] BASE_ADDR  = 10'h0f0;
  localparam logic [9:0] PCTRL_ADDR = 10'h0fe;
  localparam logic [9:0] COR_ADDR   = 10'h100;
  localparam logic [9:0] CCR_ADDR   = 10'h102;
  localparam logic [9:0] CVR_ADDR   = 10'h104;
  localparam logic [9:0] SAVE_ADDR  = 10'h106;
  localparam logic [9:0] EXT_LO     = 10'h200;
  localparam logic [9:0] EXT_HI     = 10'h3ff;

  // option register fields
  localparam int COR_SRESET    = 7;
  localparam int COR_LEVIRQ    = 6;
  localparam int COR_CONF      = 5;
  localparam int COR_WSIZE_LSB = 3;
  localparam int COR_BSEL_LSB  = 0;
  localparam logic [7:0] COR_RESET = 8'h00;
  localparam logic [7:0] CCR_RESET = 8'h00;

  // configuration register fields
  localparam int CCR_IO_BYTE_WIDE_STATUS = 5;

  // load / save sequencer
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_ERASE, SEQ_SAVE} seq_e;

endpackage

// ===== sync_2ff.sv
// two-stage synchroniser for a bundle of pin levels
// assumes inputs are quasi-static levels from outside the clock domain
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output      logic [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second; reset to ones, the idle level of
  // the active-low strobes and straps, so no false busy skip or strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

// ===== io_window_match.sv
// i/o address window comparator
// assumes base holds address bits 9:2, window of 8 << size_sel bytes
`timescale 1ns/1ps
module io_window_match (
  // window set-up
  input  wire logic [7:0] base_i,
  input  wire logic [1:0] size_sel_i,
  input  wire logic       valid_i,
  // address under test
  input  wire logic [9:0] addr_i,
  output      logic       match_n_o
);

  logic [9:0] mask;
  logic       hit;

  // base zero opens the whole i/o space
  always_comb begin
    mask = ~((10'h008 << size_sel_i) - 10'h001);
    hit  = (base_i == 8'h00) ||
           ((addr_i & mask) == ({base_i, 2'b00} & mask));
    match_n_o = ~(valid_i & hit);
  end

endmodule

// ===== card_attr_mem_io_decode.sv
// card-side attribute memory, config registers and i/o window decode
// assumes host pins are asynchronous; special function port is local
`timescale 1ns/1ps
module card_attr_mem_io_decode #(
  parameter logic [7:0] CHIP_VERSION = 8'h01 // arbitrary value
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  // host socket
  input  wire logic [9:0] host_addr_bus_i,
  input  wire logic [7:0] host_data_bus_i,
  output      logic [7:0] host_data_bus_o,
  output      logic       host_data_bus_oe_o,
  input  wire logic       card_en_even_n_i,
  input  wire logic       card_en_odd_n_i,
  input  wire logic       attr_sel_n_i,
  input  wire logic       out_en_n_i,
  input  wire logic       wr_en_n_i,
  input  wire logic       io_rd_n_i,
  input  wire logic       io_wr_n_i,
  input  wire logic       prog_volt_i,
  output      logic       irq_busy_n_o,
  // straps
  input  wire logic       test_slow_i,
  input  wire logic       eeprom_load_disable_n_i,
  input  wire logic       local_driver_disable_n_i,
  // peripheral side
  output      logic       periph_write_n_o,
  output      logic       periph_read_n_o,
  output      logic       periph_sel_byte_n_o,
  output      logic       periph_sel_word_n_o,
  input  wire logic [7:0] local_data_bus_i,
  output      logic [7:0] local_data_bus_o,
  output      logic       local_data_bus_oe_o,
  output      logic       ext_attr_chip_select_o,
  output      logic       io_byte_wide_status_o,
  output      logic [7:0] periph_ctrl_o,
  output      logic       periph_reset_o,
  // special function port
  input  wire logic       special_func_select_n_i,
  input  wire logic [6:0] sf_addr_i,
  input  wire logic [7:0] sf_wdata_i,
  input  wire logic       sf_we_i,
  output      logic [7:0] sf_rdata_o,
  // serial eeprom engine
  output      logic [6:0] ee_addr_o,
  output      logic       ee_rd_o,
  output      logic       ee_wr_o,
  output      logic       ee_erase_o,
  output      logic [7:0] ee_wdata_o,
  input  wire logic [7:0] ee_rdata_i
);

  typedef struct packed {
    card_pkg::seq_e         state;
    logic                   busy;
    logic [9:0]             tmr;
    logic [6:0]             div;
    logic [6:0]             ptr;
    logic                   phase;
    logic [127:0][7:0]      mem;
    logic [7:0]             config_option_register;
    logic [7:0]             card_config_register;
    logic                   wr_act;
    logic [9:0]             wr_addr;
    logic [7:0]             wr_data;
    logic [7:0]             hd;
    logic [7:0]             lb;
    logic [7:0]             sf_rd;
    logic                   ee_wr;
    logic                   ee_erase;
    logic [7:0]             ee_wd;
  } st_s;

  st_s        s_q;
  st_s        s_d;
  logic [44:0] pins_s;
  logic [9:0] addr_s;
  logic [7:0] data_s;
  logic [7:0] lb_s;
  logic [7:0] eed_s;
  logic       ce1_s;
  logic       ce2_s;
  logic       reg_s;
  logic       oe_s;
  logic       we_s;
  logic       iord_s;
  logic       iowr_s;
  logic       vpp_s;
  logic       test_s;
  logic       eeprom_load_disable_n_s;
  logic       local_driver_disable_n_s;
  logic       match_n;
  logic [2:0] bsel;
  logic       io_ok;
  logic       io_acc;
  logic       io_rd_ok;
  logic       io_wr_ok;
  logic       attr_rd;
  logic       wr_now;
  logic       commit;
  logic       tick;

  // all host and strap pins pass two flops
  sync_2ff #(.W(45)) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .async_i   ({host_addr_bus_i, host_data_bus_i, local_data_bus_i,
                 ee_rdata_i, card_en_even_n_i, card_en_odd_n_i,
                 attr_sel_n_i, out_en_n_i, wr_en_n_i, io_rd_n_i,
                 io_wr_n_i, prog_volt_i, test_slow_i,
                 eeprom_load_disable_n_i, local_driver_disable_n_i}),
    .sync_o    (pins_s)
  );

  assign {addr_s, data_s, lb_s, eed_s, ce1_s, ce2_s, reg_s, oe_s, we_s,
          iord_s, iowr_s, vpp_s, test_s, eeprom_load_disable_n_s, local_driver_disable_n_s} = pins_s;

  // window base taken from the loaded base address bytes
  assign bsel = s_q.config_option_register[card_pkg::COR_BSEL_LSB +: 3];

  io_window_match u_win (
    .base_i     (s_q.mem[7'(card_pkg::ATTR_BYTES) + {4'h0, bsel}]),
    .size_sel_i (s_q.config_option_register[card_pkg::COR_WSIZE_LSB +: 2]),
    .valid_i    (bsel != 3'h7),
    .addr_i     (addr_s),
    .match_n_o  (match_n)
  );

  // i/o gating and strobe pass-through
  assign io_ok    = ~s_q.busy & s_q.config_option_register[card_pkg::COR_CONF];
  assign io_acc   = io_ok & ~reg_s & ~match_n & ~(ce1_s & ce2_s);
  assign io_rd_ok = io_acc & ~iord_s;
  assign io_wr_ok = io_acc & ~iowr_s;
  assign periph_read_n_o     = ~io_rd_ok;
  assign periph_write_n_o    = ~io_wr_ok;
  assign periph_sel_word_n_o = ~(io_acc & (~iord_s | ~iowr_s) &
                                 ~ce1_s & ~ce2_s);
  assign periph_sel_byte_n_o = ~(io_acc & (~iord_s | ~iowr_s) &
                                 (ce1_s | ce2_s));

  // local bus carries host write data to the peripheral
  assign local_data_bus_o    = s_q.lb;
  assign local_data_bus_oe_o = io_wr_ok;

  // attribute reads drive only under the even enable
  assign attr_rd = ~reg_s & ~oe_s & ~ce1_s & ~s_q.busy &
                   (addr_s < card_pkg::EXT_LO);
  assign host_data_bus_o    = s_q.hd;
  assign host_data_bus_oe_o = attr_rd | (io_rd_ok & local_driver_disable_n_s);

  // extended attribute space select
  assign ext_attr_chip_select_o = ~reg_s & ~ce1_s & (~oe_s | ~we_s) &
                                  (addr_s >= card_pkg::EXT_LO) &
                                  (addr_s <= card_pkg::EXT_HI);

  // status and control outputs
  assign irq_busy_n_o = ~(s_q.busy & eeprom_load_disable_n_s);
  assign io_byte_wide_status_o = s_q.card_config_register[card_pkg::CCR_IO_BYTE_WIDE_STATUS];
  assign periph_ctrl_o  = s_q.mem[7'(card_pkg::MEM_WORDS - 1)];
  assign periph_reset_o = s_q.config_option_register[card_pkg::COR_SRESET];
  assign sf_rdata_o     = s_q.sf_rd;
  assign ee_addr_o      = s_q.ptr;
  assign ee_rd_o        = (s_q.state == card_pkg::SEQ_LOAD);
  assign ee_wr_o        = s_q.ee_wr;
  assign ee_erase_o     = s_q.ee_erase;
  assign ee_wdata_o     = s_q.ee_wd;

  // write window: data follows the bus until strobe or enable rises
  assign wr_now = ~reg_s & ~we_s & ~ce1_s;
  assign commit = s_q.wr_act & ~wr_now;
  assign tick   = s_q.div >= (test_s ? 7'(card_pkg::DIV_TEST - 1)
                                     : 7'(card_pkg::DIV_RUN - 1));

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.div = tick ? 7'h00 : s_q.div + 7'h01;
    s_d.wr_act = wr_now;
    if (wr_now) begin
      s_d.wr_addr = addr_s;
      s_d.wr_data = data_s;
    end
    s_d.lb = data_s;
    // read data for the host, registered
    if (io_rd_ok) begin
      s_d.hd = lb_s;
    end else if (addr_s[0] & ce2_s) begin
      s_d.hd = 8'h00;
    end else if (addr_s < card_pkg::COR_ADDR) begin
      s_d.hd = s_q.mem[addr_s[7:1]];
    end else if ({addr_s[9:1], 1'b0} == card_pkg::COR_ADDR) begin
      s_d.hd = s_q.config_option_register;
    end else if ({addr_s[9:1], 1'b0} == card_pkg::CCR_ADDR) begin
      s_d.hd = s_q.card_config_register;
    end else if ({addr_s[9:1], 1'b0} == card_pkg::CVR_ADDR) begin
      s_d.hd = CHIP_VERSION;
    end else begin
      s_d.hd = 8'h00;
    end
    // special function port read
    if (!special_func_select_n_i) begin
      s_d.sf_rd = s_q.mem[sf_addr_i];
    end
    // host write commit, ignored while loading
    if (commit && !s_q.busy && !s_q.wr_addr[0]) begin
      if (s_q.wr_addr < card_pkg::COR_ADDR) begin
        if (vpp_s) begin
          s_d.mem[s_q.wr_addr[7:1]] = s_q.wr_data;
        end
      end else if (s_q.wr_addr == card_pkg::COR_ADDR) begin
        if (s_q.wr_data[card_pkg::COR_SRESET]) begin
          s_d.config_option_register   = 8'h80;
          s_d.card_config_register   = card_pkg::CCR_RESET;
          s_d.state = card_pkg::SEQ_LOAD;
          s_d.busy  = 1'b1;
          s_d.tmr   = 10'h000;
          s_d.ptr   = 7'h00;
          s_d.phase = 1'b0;
        end else begin
          s_d.config_option_register = s_q.wr_data;
        end
      end else if (s_q.wr_addr == card_pkg::CCR_ADDR) begin
        s_d.card_config_register = s_q.wr_data;
      end else if (s_q.wr_addr == card_pkg::SAVE_ADDR && vpp_s &&
                   s_q.state == card_pkg::SEQ_IDLE) begin
        s_d.state = card_pkg::SEQ_ERASE;
        s_d.ptr   = 7'h00;
      end
    end else if (sf_we_i && !special_func_select_n_i) begin
      s_d.mem[sf_addr_i] = sf_wdata_i;
    end
    // load / save sequencer on the divided tick
    case (s_q.state)
      card_pkg::SEQ_LOAD: begin
        if (!eeprom_load_disable_n_s) begin
          s_d.state = card_pkg::SEQ_IDLE;
        end else if (tick) begin
          s_d.phase = ~s_q.phase;
          if (s_q.phase) begin
            s_d.mem[s_q.ptr] = eed_s;
            s_d.ptr = s_q.ptr + 7'h01;
            if (s_q.ptr == 7'(card_pkg::MEM_WORDS - 1)) begin
              s_d.state = card_pkg::SEQ_IDLE;
            end
          end
        end
      end
      card_pkg::SEQ_ERASE: begin
        if (tick) begin
          s_d.ee_erase = ~s_q.ee_erase;
          if (s_q.ee_erase) begin
            s_d.state = card_pkg::SEQ_SAVE;
          end
        end
      end
      card_pkg::SEQ_SAVE: begin
        if (tick) begin
          s_d.ee_wr = ~s_q.ee_wr;
          s_d.ee_wd = s_q.mem[s_q.ptr];
          if (s_q.ee_wr) begin
            s_d.ptr = s_q.ptr + 7'h01;
            if (s_q.ptr == 7'(card_pkg::SAVE_WORDS - 1)) begin
              s_d.state = card_pkg::SEQ_IDLE;
            end
          end
        end
      end
      default: begin
        s_d.ee_wr    = 1'b0;
        s_d.ee_erase = 1'b0;
      end
    endcase
    // busy spans the load and at least the load time
    if (s_q.busy) begin
      if (s_q.tmr != 10'(card_pkg::LOAD_CYCLES)) begin
        s_d.tmr = s_q.tmr + 10'h001;
      end
      if (s_q.state != card_pkg::SEQ_LOAD &&
          s_q.tmr >= 10'(card_pkg::LOAD_CYCLES - 1)) begin
        s_d.busy = 1'b0;
      end
    end
  end

  // state register; reset starts a load, config cleared
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q       <= '0;
      s_q.state <= card_pkg::SEQ_LOAD;
      s_q.busy  <= 1'b1;
      s_q.config_option_register   <= card_pkg::COR_RESET;
      s_q.card_config_register   <= card_pkg::CCR_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // checks
  chk_load_holds_busy: assert property (
    s_q.state == card_pkg::SEQ_LOAD |-> s_q.busy && irq_busy_n_o != eeprom_load_disable_n_s)
    else $error("busy not shown during load");

  chk_busy_min_time: assert property (
    $fell(s_q.busy) |-> $past(s_q.tmr) >= 10'(card_pkg::LOAD_CYCLES - 1))
    else $error("busy released before load time");

  chk_soft_reload: assert property (
    commit && !s_q.busy && s_q.wr_addr == card_pkg::COR_ADDR &&
    s_q.wr_data[card_pkg::COR_SRESET]
    |=> s_q.state == card_pkg::SEQ_LOAD && s_q.busy && s_q.card_config_register == 8'h00)
    else $error("soft reset did not restart load");

  chk_cis_protect: assert property (
    commit && !vpp_s && s_q.wr_addr < card_pkg::COR_ADDR
    && !(sf_we_i && !special_func_select_n_i) && s_q.state == card_pkg::SEQ_IDLE
    |=> $stable(s_q.mem))
    else $error("attribute memory written without voltage");

  chk_write_stored: assert property (
    commit && vpp_s && !s_q.busy && !s_q.wr_addr[0] &&
    s_q.wr_addr < card_pkg::BASE_ADDR && s_q.state == card_pkg::SEQ_IDLE
    |=> s_q.mem[$past(s_q.wr_addr[7:1])] == $past(s_q.wr_data))
    else $error("last write data not stored");

  chk_save_erases: assert property (
    commit && !s_q.busy && vpp_s && s_q.wr_addr == card_pkg::SAVE_ADDR &&
    s_q.state == card_pkg::SEQ_IDLE
    |=> s_q.state == card_pkg::SEQ_ERASE ##[0:260] ee_erase_o)
    else $error("save did not start with erase");

  chk_ext_range: assert property (
    ext_attr_chip_select_o |-> addr_s >= card_pkg::EXT_LO && !ce1_s)
    else $error("external select outside its range");

  chk_odd_float: assert property (
    ce1_s && !io_rd_ok |-> !host_data_bus_oe_o)
    else $error("data driven without even enable");

  chk_sel_window: assert property (
    !periph_sel_byte_n_o || !periph_sel_word_n_o
    |-> !match_n && io_ok && !reg_s)
    else $error("peripheral select outside window");

  chk_strobe_gate: assert property (
    s_q.busy || !s_q.config_option_register[card_pkg::COR_CONF]
    |-> periph_write_n_o && periph_read_n_o)
    else $error("i/o strobe forwarded while unconfigured");

  chk_sf_gate: assert property (
    $changed(s_q.sf_rd) |-> $past(!special_func_select_n_i))
    else $error("special port read without select");

  cov_load_done: cover property ($fell(s_q.busy));
  cov_save_done: cover property (
    s_q.state == card_pkg::SEQ_SAVE ##1 s_q.state == card_pkg::SEQ_IDLE);
  cov_io_write: cover property ($fell(periph_write_n_o));
  cov_attr_read: cover property ($rose(host_data_bus_oe_o) && attr_rd);

endmodule

// ===== card_host_model.sv
// host socket model: runs attribute and i/o cycles on the card pins
// assumes callers step it from the testbench on sys_clk_i edges
`timescale 1ns/1ps
module card_host_model (
  // clock
  input  wire logic       sys_clk_i,
  // card pins
  output      logic [9:0] addr_o,
  output      logic [7:0] data_o,
  output      logic       ce_even_n_o,
  output      logic       ce_odd_n_o,
  output      logic       attr_sel_n_o,
  output      logic       out_en_n_o,
  output      logic       wr_en_n_o,
  output      logic       io_rd_n_o,
  output      logic       io_wr_n_o,
  output      logic       prog_volt_o
);
  // all strobes and enables idle high at time zero
  initial begin
    addr_o = 10'h000;
    data_o = 8'h00;
    {ce_even_n_o, ce_odd_n_o, out_en_n_o, wr_en_n_o} = 4'hf;
    {io_rd_n_o, io_wr_n_o, attr_sel_n_o} = 3'h7;
    prog_volt_o = 1'b0;
  end
  // open a cycle: address, data, enables and strobes move together
  task automatic start(input logic [9:0] a, input logic [7:0] d,
                       input logic [5:0] n);
    @(posedge sys_clk_i);
    addr_o <= a;
    data_o <= d;
    attr_sel_n_o <= 1'b0;
    {ce_even_n_o, ce_odd_n_o, out_en_n_o, wr_en_n_o, io_rd_n_o,
     io_wr_n_o} <= n;
  endtask
  // close a cycle; released data goes inverse, then idle for the syncs
  task automatic stop();
    @(posedge sys_clk_i);
    {ce_even_n_o, ce_odd_n_o, out_en_n_o, wr_en_n_o} <= 4'hf;
    {io_rd_n_o, io_wr_n_o, attr_sel_n_o} <= 3'h7;
    data_o <= ~data_o;
    repeat (3) @(posedge sys_clk_i);
  endtask
  // programming voltage level
  task automatic set_vpp(input logic v);
    @(posedge sys_clk_i);
    prog_volt_o <= v;
  endtask
endmodule

// ===== card_attr_mem_io_decode_tb.sv
// testbench for the card attribute memory and i/o decode block
// assumes card_pkg and card_host_model are compiled first
`timescale 1ns/1ps
module card_attr_mem_io_decode_tb;
  localparam logic [5:0] RD = 6'b010111;
  localparam logic [5:0] WR = 6'b011011;
  localparam logic [5:0] IW = 6'b011110;
  localparam logic [5:0] IR = 6'b011101;
  // clock, reset, straps and special function port
  logic       sys_clk  = 1'b0;
  logic       rst      = 1'b1;
  logic       ee_dis_n = 1'b1;
  logic       sf_sel_n = 1'b1;
  logic       sf_we    = 1'b0;
  logic [6:0] sf_addr  = 7'h00;
  logic [7:0] sf_wdata = 8'h00;
  // host pins and card outputs
  logic [9:0] ha;
  logic [7:0] hd, rdata, pctrl, ee_rdata, s_rd, lb, s_lb, sf_rd;
  logic [6:0] ee_addr;
  logic [4:0] s_io;
  logic       ce_e_n, ce_o_n, sel_n, oe_n, we_n, ird_n, iwr_n, vpp;
  logic       rd_oe, busy_n, pw_n, pr_n, psb_n, psw_n, ext_cs, io8;
  logic       preset, ld_oe, ee_wr, ee_er, s_oe;
  logic       wr_p = 1'b0;
  logic       er_p = 1'b0;
  int         err_total = 0;
  int         n_tests   = 0;
  int         n_wr      = 0;
  int         n_er      = 0;

  always #2.5 sys_clk = ~sys_clk;

  card_host_model i_card_host_model (
    .sys_clk_i(sys_clk), .addr_o(ha), .data_o(hd), .ce_even_n_o(ce_e_n),
    .ce_odd_n_o(ce_o_n), .attr_sel_n_o(sel_n), .out_en_n_o(oe_n),
    .wr_en_n_o(we_n), .io_rd_n_o(ird_n), .io_wr_n_o(iwr_n),
    .prog_volt_o(vpp));

  card_attr_mem_io_decode i_card_attr_mem_io_decode (
    .sys_clk_i(sys_clk), .rst_i(rst), .host_addr_bus_i(ha),
    .host_data_bus_i(hd), .host_data_bus_o(rdata),
    .host_data_bus_oe_o(rd_oe), .card_en_even_n_i(ce_e_n),
    .card_en_odd_n_i(ce_o_n), .attr_sel_n_i(sel_n), .out_en_n_i(oe_n),
    .wr_en_n_i(we_n), .io_rd_n_i(ird_n), .io_wr_n_i(iwr_n),
    .prog_volt_i(vpp), .irq_busy_n_o(busy_n), .test_slow_i(1'b0),
    .eeprom_load_disable_n_i(ee_dis_n), .local_driver_disable_n_i(1'b1),
    .periph_write_n_o(pw_n), .periph_read_n_o(pr_n),
    .periph_sel_byte_n_o(psb_n), .periph_sel_word_n_o(psw_n),
    .local_data_bus_i(8'h3c), .local_data_bus_o(lb),
    .local_data_bus_oe_o(ld_oe), .ext_attr_chip_select_o(ext_cs),
    .io_byte_wide_status_o(io8), .periph_ctrl_o(pctrl),
    .periph_reset_o(preset), .special_func_select_n_i(sf_sel_n),
    .sf_addr_i(sf_addr), .sf_wdata_i(sf_wdata), .sf_we_i(sf_we),
    .sf_rdata_o(sf_rd), .ee_addr_o(ee_addr), .ee_rd_o(), .ee_wr_o(ee_wr),
    .ee_erase_o(ee_er), .ee_wdata_o(), .ee_rdata_i(ee_rdata));

  // eeprom image: byte n holds n xor 5ah
  assign ee_rdata = {1'b0, ee_addr} ^ 8'h5a;
  function automatic logic [7:0] img(input int n);
    return n[7:0] ^ 8'h5a;
  endfunction

  // count eeprom write and erase pulses
  always @(negedge sys_clk) begin
    wr_p <= ee_wr;
    er_p <= ee_er;
    if (ee_wr === 1'b1 && wr_p !== 1'b1) n_wr++;
    if (ee_er === 1'b1 && er_p !== 1'b1) n_er++;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic tmo(input string nm);
    err_total++;
    $display("unexpected %s: expected done seen timeout", nm);
    conclude();
  endtask

  // one host cycle, outputs sampled mid-cycle once settled
  task automatic acc(input logic [9:0] a, input logic [7:0] d,
                     input logic [5:0] n);
    i_card_host_model.start(a, d, n);
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    s_rd = rdata;
    s_oe = rd_oe;
    s_lb = lb;
    s_io = {pw_n, pr_n, psb_n & psw_n, ext_cs, ld_oe};
    i_card_host_model.stop();
  endtask

  // host holds off until busy lifts
  task automatic wait_ready(output int c);
    c = 0;
    while (busy_n !== 1'b1) begin
      @(posedge sys_clk);
      c++;
      if (c > 6000) tmo("load");
    end
  endtask

  task automatic t_load();
    int c;
    repeat (3) @(posedge sys_clk);
    chk("busy", 8'(busy_n), 8'h00);
    wait_ready(c);
    chk("load time", 8'(c >= card_pkg::LOAD_CYCLES - 3), 8'h01);
    chk("pctrl", pctrl, img(127));
    chk("io8 reset", 8'(io8), 8'h00);
  endtask

  task automatic t_read();
    acc(10'h000, 8'h00, RD);
    chk("rd 000", s_rd, img(0));
    chk("rd oe", 8'(s_oe), 8'h01);
    acc(10'h0ee, 8'h00, RD);
    chk("rd 0ee", s_rd, img(119));
    acc(10'h0f0, 8'h00, RD);
    chk("rd base0", s_rd, img(120));
    acc(10'h001, 8'h00, RD);
    chk("rd odd", s_rd, 8'h00);
    acc(10'h002, 8'h00, 6'b000111);
    chk("rd both", s_rd, img(1));
    acc(10'h002, 8'h00, 6'b100111);
    chk("oe odd only", 8'(s_oe), 8'h00);
    acc(10'h002, 8'h00, 6'b110111);
    chk("oe standby", 8'(s_oe), 8'h00);
    acc(10'h200, 8'h00, RD);
    chk("ext 200", 8'(s_io[1]), 8'h01);
    acc(10'h3fe, 8'h00, RD);
    chk("ext 3fe", 8'(s_io[1]), 8'h01);
    acc(10'h1fe, 8'h00, RD);
    chk("ext 1fe", 8'(s_io[1]), 8'h00);
  endtask

  task automatic t_write();
    acc(10'h004, 8'ha5, WR);
    acc(10'h004, 8'h00, RD);
    chk("wr protect", s_rd, img(2));
    i_card_host_model.set_vpp(1'b1);
    acc(10'h004, 8'ha5, WR);
    i_card_host_model.set_vpp(1'b0);
    acc(10'h004, 8'h00, RD);
    chk("wr vpp", s_rd, 8'ha5);
    chk("no ee wr", 8'(n_wr), 8'h00);
  endtask

  task automatic t_io();
    logic [9:0] b;
    b = {img(120), 2'b00};
    acc(b, 8'h11, IW);
    chk("io unconf", 8'(s_io[4]), 8'h01);
    acc(card_pkg::COR_ADDR, 8'h20, WR);
    acc(card_pkg::COR_ADDR, 8'h00, RD);
    chk("cor", s_rd, 8'h20);
    acc(b + 10'h007, 8'h11, IW);
    chk("iwr in", {s_io[4], s_io[2], s_io[0]}, 8'h01);
    chk("lbus wr", s_lb, 8'h11);
    acc(b + 10'h002, 8'h00, IR);
    chk("ird in", {s_io[3:2]}, 8'h00);
    chk("ird data", s_rd, 8'h3c);
    acc(b + 10'h008, 8'h11, IW);
    chk("iwr out", {s_io[4], s_io[2]}, 8'h03);
    acc(b - 10'h002, 8'h00, IR);
    chk("ird out", 8'(s_io[3]), 8'h01);
    acc(card_pkg::CCR_ADDR, 8'h01 << card_pkg::CCR_IO_BYTE_WIDE_STATUS, WR);
    @(negedge sys_clk);
    chk("io8 set", 8'(io8), 8'h01);
  endtask

  task automatic t_sf();
    @(posedge sys_clk);
    sf_addr <= 7'h03;
    sf_wdata <= 8'hc3;
    sf_we <= 1'b1;
    @(posedge sys_clk);
    sf_we <= 1'b0;
    acc(10'h006, 8'h00, RD);
    chk("sf off", s_rd, img(3));
    sf_sel_n <= 1'b0;
    sf_we <= 1'b1;
    @(posedge sys_clk);
    sf_we <= 1'b0;
    sf_sel_n <= 1'b1;
    acc(10'h006, 8'h00, RD);
    chk("sf on", s_rd, 8'hc3);
    sf_sel_n <= 1'b0;
    @(posedge sys_clk);
    sf_sel_n <= 1'b1;
    @(negedge sys_clk);
    chk("sf rdata", sf_rd, 8'hc3);
  endtask

  task automatic t_save();
    int w0;
    int e0;
    int i;
    w0 = n_wr;
    e0 = n_er;
    i_card_host_model.set_vpp(1'b1);
    acc(card_pkg::SAVE_ADDR, 8'h00, WR);
    i_card_host_model.set_vpp(1'b0);
    for (i = 0; n_wr - w0 < card_pkg::SAVE_WORDS; i++) begin
      @(posedge sys_clk);
      if (i > 8000) tmo("save");
    end
    repeat (40) @(posedge sys_clk);
    chk("save n", 8'(n_wr - w0), 8'(card_pkg::SAVE_WORDS));
    chk("erase n", 8'(n_er - e0), 8'h01);
  endtask

  task automatic t_soft();
    int c;
    acc(card_pkg::COR_ADDR, 8'h80, WR);
    for (c = 0; busy_n !== 1'b0; c++) begin
      @(posedge sys_clk);
      if (c > 20) tmo("soft busy");
    end
    chk("soft prst", 8'(preset), 8'h01);
    wait_ready(c);
    acc(10'h004, 8'h00, RD);
    chk("reload", s_rd, img(2));
    chk("ccr clr", 8'(io8), 8'h00);
  endtask

  task automatic t_nobusy();
    @(posedge sys_clk);
    ee_dis_n <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("no busy", 8'(busy_n), 8'h01);
  endtask

  // reset, then scenarios in order
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_load();
    t_read();
    t_write();
    t_io();
    t_sf();
    t_save();
    t_soft();
    t_nobusy();
    conclude();
  end
endmodule
